// >>> link_pkg.sv
// shared constants and command type for the two-wire link ends
package link_pkg;

	// target address, selected by the address select strap
	localparam logic [6:0] ADDR_SEL_LOW  = 7'h18;
	localparam logic [6:0] ADDR_SEL_HIGH = 7'h19;

	// timing
	localparam int CLK_KHZ     = 250000;
	localparam int SCL_KHZ     = 1000;
	localparam int STRETCH_NS  = 1000;
	// least quarter period of the generated bus clock, rounded up
	localparam int QTR_CYC     = (CLK_KHZ + 4 * SCL_KHZ - 1) / (4 * SCL_KHZ);
	// longest stretch, rounded down
	localparam int STRETCH_CYC = STRETCH_NS * (CLK_KHZ / 1000) / 1000;

	// field widths and positions
	localparam int BYTE_W   = 8;
	localparam int BITS_W   = 4;
	localparam int MSB      = 7;
	localparam int ACK_SLOT = 8;
	localparam int TIMER_W  = 8;
	localparam int QTR_W    = 6;

	// idle level of the synchronised bus lines
	localparam logic [1:0] LINES_IDLE = 2'h3;
	localparam logic [7:0] READ_FILL  = 8'hff;

	// primary command set
	typedef enum logic [2:0] {
		bus_start,
		byte_write,
		byte_read_ack,
		byte_read_nack,
		bus_stop
	} host_op_t;

endpackage

// >>> two_wire_if.sv
// open-drain clock and data lines joining the primary and the target
interface two_wire_if;
	logic host_scl_out;
	logic host_scl_oe;
	logic host_sda_out;
	logic host_sda_oe;
	logic dev_scl_out;
	logic dev_scl_oe;
	logic dev_sda_out;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// wired-and with pull-ups: any enabled low driver wins
	assign scl = ~((host_scl_oe & ~host_scl_out) | (dev_scl_oe & ~dev_scl_out));
	assign sda = ~((host_sda_oe & ~host_sda_out) | (dev_sda_oe & ~dev_sda_out));

	modport primary (
		output host_scl_out,
		output host_scl_oe,
		output host_sda_out,
		output host_sda_oe,
		input  scl,
		input  sda
	);

	modport target (
		output dev_scl_out,
		output dev_scl_oe,
		output dev_sda_out,
		output dev_sda_oe,
		input  scl,
		input  sda
	);
endinterface

// >>> i2c_primary.sv
// bus primary end: byte-level command engine with generated bus clock
module i2c_primary (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              resetn,
	input  wire logic              ce,
	// bus
	two_wire_if.primary            link,
	// command
	input  wire logic              cmd_valid,
	output logic                   cmd_ready,
	input  wire link_pkg::host_op_t cmd_op,
	input  wire logic [7:0]        cmd_data,
	// response
	output logic                   rsp_valid,
	output logic [7:0]             rsp_data,
	output logic                   rsp_nack
);

	typedef enum logic [1:0] {idle, cond_start, cond_stop, xfer} state_t;

	state_t             state_reg, state_next;
	link_pkg::host_op_t op_reg, op_next;
	logic [1:0]         meta_reg, pin_reg;
	logic [1:0]         phase_reg, phase_next;
	logic [5:0]         timer_reg, timer_next;
	logic [3:0]         bits_reg, bits_next;
	logic [7:0]         shift_reg, shift_next;
	logic               scl_low_reg, scl_low_next;
	logic               sda_low_reg, sda_low_next;
	logic               rsp_valid_reg, rsp_valid_next;
	logic [7:0]         rsp_data_reg, rsp_data_next;
	logic               rsp_nack_reg, rsp_nack_next;

	////////////////////////////////////////////////////////////////////////
	wire       scl_s   = pin_reg[0];
	wire       sda_s   = pin_reg[1];
	// high phase waits for the line to rise: honours target stretching
	wire       hold    = (phase_reg == 2'h1) & ~scl_s;
	wire       adv     = (timer_reg == 6'(link_pkg::QTR_CYC - 1)) & ~hold;
	wire       is_wr   = (op_reg == link_pkg::byte_write);
	wire [3:0] bits_up = bits_reg + 4'h1;

	assign cmd_ready         = (state_reg == idle);
	assign rsp_valid         = rsp_valid_reg;
	assign rsp_data          = rsp_data_reg;
	assign rsp_nack          = rsp_nack_reg;
	assign link.host_scl_out = 1'b0;
	assign link.host_sda_out = 1'b0;
	assign link.host_scl_oe  = scl_low_reg;
	assign link.host_sda_oe  = sda_low_reg;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_next     = state_reg;
		op_next        = op_reg;
		phase_next     = phase_reg;
		timer_next     = state_reg == idle ? 6'h0 : (adv ? 6'h0 : (hold ? timer_reg : timer_reg + 6'h1));
		bits_next      = bits_reg;
		shift_next     = shift_reg;
		scl_low_next   = scl_low_reg;
		sda_low_next   = sda_low_reg;
		rsp_valid_next = 1'b0;
		rsp_data_next  = rsp_data_reg;
		rsp_nack_next  = rsp_nack_reg;
		unique case (state_reg)
			idle: if (cmd_valid) begin
				op_next    = cmd_op;
				phase_next = 2'h0;
				bits_next  = 4'h0;
				unique case (cmd_op)
					link_pkg::bus_start: begin
						state_next   = cond_start;
						sda_low_next = 1'b0;
					end
					link_pkg::bus_stop: begin
						state_next   = cond_stop;
						sda_low_next = 1'b1;
					end
					link_pkg::byte_write: begin
						state_next   = xfer;
						shift_next   = cmd_data;
						sda_low_next = ~cmd_data[link_pkg::MSB];
					end
					default: begin
						state_next   = xfer;
						shift_next   = link_pkg::READ_FILL;
						sda_low_next = 1'b0; // RQ9
					end
				endcase
			end
			default: if (adv) begin
				phase_next = phase_reg + 2'h1;
				unique case (phase_reg)
					2'h0: scl_low_next = 1'b0;
					2'h1: begin
						if (state_reg == cond_start)
							sda_low_next = 1'b1; // RQ3 RQ17
						else if (state_reg == cond_stop)
							sda_low_next = 1'b0; // RQ14 RQ15
						else if (bits_reg == 4'(link_pkg::ACK_SLOT))
							rsp_nack_next = sda_s;
						else
							shift_next = {shift_reg[6:0], sda_s};
					end
					2'h2: begin
						if (state_reg == cond_stop)
							state_next = idle;
						else
							scl_low_next = 1'b1;
					end
					2'h3: begin
						bits_next = bits_up;
						if (state_reg == cond_start) begin
							state_next = idle;
						end else if (bits_reg == 4'(link_pkg::ACK_SLOT)) begin
							state_next     = idle;
							sda_low_next   = 1'b0;
							rsp_valid_next = 1'b1;
							rsp_data_next  = shift_reg;
						end else if (bits_up == 4'(link_pkg::ACK_SLOT)) begin
							// acknowledge low, or leave last read byte unacknowledged
							sda_low_next = (op_reg == link_pkg::byte_read_ack); // RQ9 RQ10 RQ16
						end else begin
							sda_low_next = is_wr & ~shift_reg[link_pkg::MSB];
						end
					end
				endcase
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_reg      <= link_pkg::LINES_IDLE;
			pin_reg       <= link_pkg::LINES_IDLE;
			state_reg     <= idle;
			op_reg        <= link_pkg::bus_start;
			phase_reg     <= 2'h0;
			timer_reg     <= 6'h0;
			bits_reg      <= 4'h0;
			shift_reg     <= 8'h0;
			scl_low_reg   <= 1'b0;
			sda_low_reg   <= 1'b0;
			rsp_valid_reg <= 1'b0;
			rsp_data_reg  <= 8'h0;
			rsp_nack_reg  <= 1'b0;
		end else if (ce) begin
			meta_reg      <= {link.sda, link.scl};
			pin_reg       <= meta_reg;
			state_reg     <= state_next;
			op_reg        <= op_next;
			phase_reg     <= phase_next;
			timer_reg     <= timer_next;
			bits_reg      <= bits_next;
			shift_reg     <= shift_next;
			scl_low_reg   <= scl_low_next;
			sda_low_reg   <= sda_low_next;
			rsp_valid_reg <= rsp_valid_next;
			rsp_data_reg  <= rsp_data_next;
			rsp_nack_reg  <= rsp_nack_next;
		end
	end

endmodule

// >>> accel_i2c_target_port.sv
// target end of the two-wire register port
//
// Overview of operation
// RQ1: own address 18h, or 19h with select high
// RQ2: first byte is address then read/write bit
// RQ3: start is data falling while clock high
// RQ4: bus busy from start until stop
// RQ5: idle bus: both lines released
// RQ6: seven address bits, then read=1 write=0
// RQ7: selected only when address matches own; the selected output is also high while any address is received
// RQ8: ninth clock of every byte is acknowledge
// RQ9: transmitter releases data during acknowledge
// RQ10: receiver holds data low through acknowledge
// RQ11: no limit on bytes per transfer
// RQ12: read clock stretch at most 1 us
// RQ13: stretch only after primary acknowledge
// RQ14: stop is data rising while clock high
// RQ15: primary ends every write with stop
// RQ16: primary ends read with nack, stop
// RQ17: repeated start restarts address reception
// RQ18: port active only with interface select low
// RQ19: first written byte sets register pointer
// RQ20: read: set pointer, repeated start, read
// RQ21: pointer advances after each data byte; not after a read byte the primary nacks
// RQ22: address miss: release, wait for start
// RQ23: after read nack, release data line
module accel_i2c_target_port (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       ce,
	// bus
	two_wire_if.target      link,
	// straps
	input  wire logic       address_select_pin,
	input  wire logic       interface_select_pin,
	// register file side
	output logic [7:0]      reg_ptr,
	output logic            wr_strobe,
	output logic [7:0]      wr_addr,
	output logic [7:0]      wr_data,
	output logic            rd_req,
	input  wire logic [7:0] rd_data,
	input  wire logic       rd_valid,
	// status
	output logic            bus_busy,
	output logic            selected
);

	typedef enum logic [2:0] {ignore, addr_rx, ack_tx, data_rx, data_tx, ack_rx, stretch} state_t;

	state_t     state_reg, state_next;
	logic [3:0] meta_reg, pin_reg;
	logic       scl_q_reg, sda_q_reg;
	logic [3:0] bits_reg, bits_next;
	logic [7:0] shift_reg, shift_next;
	logic [7:0] tx_reg, tx_next;
	logic [7:0] ptr_reg, ptr_next;
	logic [7:0] buf_reg, buf_next;
	logic       buf_ok_reg, buf_ok_next;
	logic [7:0] timer_reg, timer_next;
	logic       rnw_reg, rnw_next;
	logic       first_reg, first_next;
	logic       nack_reg, nack_next;
	logic       sda_oe_reg, sda_oe_next;
	logic       scl_oe_reg, scl_oe_next;
	logic       busy_reg, busy_next;
	logic       wr_strobe_reg, wr_strobe_next;
	logic [7:0] wr_addr_reg, wr_addr_next;
	logic [7:0] wr_data_reg, wr_data_next;
	logic       rd_req_reg, rd_req_next;

	////////////////////////////////////////////////////////////////////////
	// synchronised lines and straps
	wire scl_s = pin_reg[0];
	wire sda_s = pin_reg[1];
	wire asel  = pin_reg[2];
	wire intf  = pin_reg[3];

	wire       scl_rise    = scl_s & ~scl_q_reg;
	wire       scl_fall    = ~scl_s & scl_q_reg;
	wire       start_det   = scl_s & scl_q_reg & sda_q_reg & ~sda_s; // RQ3
	wire       stop_det    = scl_s & scl_q_reg & ~sda_q_reg & sda_s; // RQ14
	wire [6:0] own_addr    = asel ? link_pkg::ADDR_SEL_HIGH : link_pkg::ADDR_SEL_LOW; // RQ1
	wire       addr_hit    = (shift_reg[7:1] == own_addr) & ~intf; // RQ2 RQ6 RQ7 RQ18
	wire       byte_done   = (bits_reg == 4'(link_pkg::ACK_SLOT)); // RQ8
	wire       stretch_end = buf_ok_reg | (timer_reg == 8'(link_pkg::STRETCH_CYC - 1)); // RQ12

	assign reg_ptr          = ptr_reg;
	assign wr_strobe        = wr_strobe_reg;
	assign wr_addr          = wr_addr_reg;
	assign wr_data          = wr_data_reg;
	assign rd_req           = rd_req_reg;
	assign bus_busy         = busy_reg;
	assign selected         = (state_reg != ignore);
	assign link.dev_scl_out = 1'b0;
	assign link.dev_sda_out = 1'b0;
	assign link.dev_scl_oe  = scl_oe_reg;
	assign link.dev_sda_oe  = sda_oe_reg;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_next     = state_reg;
		bits_next      = bits_reg;
		shift_next     = shift_reg;
		tx_next        = tx_reg;
		ptr_next       = ptr_reg;
		buf_next       = buf_reg;
		buf_ok_next    = buf_ok_reg;
		timer_next     = (state_reg == stretch) ? timer_reg + 8'h1 : 8'h0;
		rnw_next       = rnw_reg;
		first_next     = first_reg;
		nack_next      = nack_reg;
		sda_oe_next    = sda_oe_reg;
		scl_oe_next    = scl_oe_reg;
		busy_next      = busy_reg;
		wr_strobe_next = 1'b0;
		wr_addr_next   = wr_addr_reg;
		wr_data_next   = wr_data_reg;
		rd_req_next    = 1'b0;
		if (rd_valid) begin
			buf_next    = rd_data;
			buf_ok_next = 1'b1;
		end
		if (start_det)
			busy_next = 1'b1; // RQ4
		else if (stop_det)
			busy_next = 1'b0; // RQ4
		if (start_det) begin
			// also a repeated start: drop whatever was under way
			state_next  = addr_rx; // RQ17
			bits_next   = 4'h0;
			sda_oe_next = 1'b0;
			scl_oe_next = 1'b0;
		end else if (stop_det) begin
			state_next  = ignore; // RQ5
			sda_oe_next = 1'b0;
			scl_oe_next = 1'b0;
		end else begin
			unique case (state_reg)
				ignore: ; // RQ22
				addr_rx, data_rx: begin
					if (scl_rise & ~byte_done) begin
						shift_next = {shift_reg[6:0], sda_s};
						bits_next  = bits_reg + 4'h1;
					end
					if (scl_fall & byte_done) begin
						bits_next = 4'h0; // RQ11
						if (state_reg == addr_rx) begin
							if (addr_hit) begin
								state_next  = ack_tx;
								sda_oe_next = 1'b1; // RQ10
								rnw_next    = shift_reg[0];
								first_next  = 1'b1;
								// fetch the first read byte from the current pointer
								rd_req_next = shift_reg[0]; // RQ20
								if (shift_reg[0])
									buf_ok_next = 1'b0;
							end else begin
								state_next = ignore; // RQ22
							end
						end else begin
							state_next  = ack_tx;
							sda_oe_next = 1'b1; // RQ10
							first_next  = 1'b0;
							if (first_reg) begin
								ptr_next = shift_reg; // RQ19
							end else begin
								wr_strobe_next = 1'b1;
								wr_addr_next   = ptr_reg;
								wr_data_next   = shift_reg;
								ptr_next       = ptr_reg + 8'h1; // RQ21
							end
						end
					end
				end
				ack_tx: if (scl_fall) begin
					bits_next = 4'h0;
					if (rnw_reg) begin
						state_next  = data_tx;
						tx_next     = buf_reg;
						sda_oe_next = ~buf_reg[link_pkg::MSB];
					end else begin
						state_next  = data_rx;
						sda_oe_next = 1'b0;
					end
				end
				data_tx: begin
					if (scl_rise)
						bits_next = bits_reg + 4'h1;
					if (scl_fall) begin
						if (byte_done) begin
							state_next  = ack_rx;
							sda_oe_next = 1'b0; // RQ9
						end else begin
							tx_next     = {tx_reg[6:0], 1'b1};
							sda_oe_next = ~tx_reg[6];
						end
					end
				end
				ack_rx: begin
					if (scl_rise)
						nack_next = sda_s;
					if (scl_fall) begin
						if (nack_reg) begin
							state_next = ignore; // RQ23
						end else begin
							// hold the clock while the next byte is fetched
							state_next  = stretch; // RQ13
							scl_oe_next = 1'b1;
							ptr_next    = ptr_reg + 8'h1; // RQ21
							rd_req_next = 1'b1;
							buf_ok_next = 1'b0;
						end
					end
				end
				stretch: if (stretch_end) begin
					state_next  = data_tx; // RQ12
					scl_oe_next = 1'b0;
					bits_next   = 4'h0;
					tx_next     = buf_reg;
					sda_oe_next = ~buf_reg[link_pkg::MSB];
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_reg      <= {2'h0, link_pkg::LINES_IDLE};
			pin_reg       <= {2'h0, link_pkg::LINES_IDLE};
			scl_q_reg     <= 1'b1;
			sda_q_reg     <= 1'b1;
			state_reg     <= ignore;
			bits_reg      <= 4'h0;
			shift_reg     <= 8'h0;
			tx_reg        <= 8'h0;
			ptr_reg       <= 8'h0;
			buf_reg       <= 8'h0;
			buf_ok_reg    <= 1'b0;
			timer_reg     <= 8'h0;
			rnw_reg       <= 1'b0;
			first_reg     <= 1'b0;
			nack_reg      <= 1'b0;
			sda_oe_reg    <= 1'b0;
			scl_oe_reg    <= 1'b0;
			busy_reg      <= 1'b0;
			wr_strobe_reg <= 1'b0;
			wr_addr_reg   <= 8'h0;
			wr_data_reg   <= 8'h0;
			rd_req_reg    <= 1'b0;
		end else if (ce) begin
			meta_reg      <= {interface_select_pin, address_select_pin, link.sda, link.scl};
			pin_reg       <= meta_reg;
			scl_q_reg     <= scl_s;
			sda_q_reg     <= sda_s;
			state_reg     <= state_next;
			bits_reg      <= bits_next;
			shift_reg     <= shift_next;
			tx_reg        <= tx_next;
			ptr_reg       <= ptr_next;
			buf_reg       <= buf_next;
			buf_ok_reg    <= buf_ok_next;
			timer_reg     <= timer_next;
			rnw_reg       <= rnw_next;
			first_reg     <= first_next;
			nack_reg      <= nack_next;
			sda_oe_reg    <= sda_oe_next;
			scl_oe_reg    <= scl_oe_next;
			busy_reg      <= busy_next;
			wr_strobe_reg <= wr_strobe_next;
			wr_addr_reg   <= wr_addr_next;
			wr_data_reg   <= wr_data_next;
			rd_req_reg    <= rd_req_next;
		end
	end

endmodule

// >>> accel_i2c_target_port_chk.sv
// wire-level checker for the two-wire link between primary and target
module accel_i2c_target_port_chk (
	// clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// link
	input  wire logic dev_scl_oe,
	input  wire logic dev_sda_oe,
	input  wire logic scl,
	input  wire logic sda,
	// straps
	input  wire logic address_select_pin,
	input  wire logic interface_select_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       scl_reg, sda_reg, busy_reg, first_reg, sel_reg, rd_reg, miss_reg, pack_reg;
	logic [3:0] bits_reg;
	logic [7:0] shift_reg;
	logic [8:0] hold_reg;
	wire        start_det = scl && scl_reg && sda_reg && !sda;
	wire        stop_det  = scl && scl_reg && !sda_reg && sda;
	wire        scl_rise  = scl && !scl_reg;
	wire        ack_rise  = scl_rise && bits_reg == 4'h8;
	wire [6:0]  own_addr  = address_select_pin ? link_pkg::ADDR_SEL_HIGH : link_pkg::ADDR_SEL_LOW;
	wire        hit       = shift_reg[7:1] == own_addr && !interface_select_pin;

	////////////////////////////////////////////////////////////////
	// bus tracking: frame state, bit count, address decode
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			{scl_reg, sda_reg} <= link_pkg::LINES_IDLE;
			{busy_reg, first_reg, sel_reg, rd_reg, miss_reg, pack_reg} <= 6'h00;
			bits_reg <= 4'h0;
			shift_reg <= 8'h00;
			hold_reg <= 9'h000;
		end else begin
			scl_reg <= scl;
			sda_reg <= sda;
			hold_reg <= dev_scl_oe ? hold_reg + 9'h001 : 9'h000;
			if (start_det || stop_det) begin
				{busy_reg, first_reg} <= {start_det, start_det};
				{sel_reg, miss_reg, pack_reg} <= 3'h0;
				bits_reg <= 4'h0;
			end else if (ack_rise) begin
				bits_reg <= 4'h0;
				first_reg <= 1'b0;
				pack_reg <= !first_reg && sel_reg && rd_reg && !sda;
				if (first_reg) begin
					{sel_reg, rd_reg, miss_reg} <= {hit, shift_reg[0], !hit};
				end
			end else if (scl_rise) begin
				bits_reg <= bits_reg + 4'h1;
				shift_reg <= {shift_reg[6:0], sda};
			end
		end
	end

	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	a_idle_free: assert property (!busy_reg |-> !dev_sda_oe && !dev_scl_oe)
		else $error("target drives a free bus");
	a_addr_ack: assert property (ack_rise && first_reg |-> sda == !hit)
		else $error("address acknowledge wrong");
	a_wr_ack: assert property (ack_rise && !first_reg && sel_reg && !rd_reg |-> dev_sda_oe)
		else $error("written byte not acknowledged");
	a_rd_release: assert property (ack_rise && !first_reg && sel_reg && rd_reg |-> !dev_sda_oe)
		else $error("data held in read acknowledge");
	a_miss_quiet: assert property (miss_reg |-> !dev_sda_oe && !dev_scl_oe)
		else $error("unselected target drives bus");
	a_sda_steady: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
		else $error("data changed while clock high");
	a_stretch_bound: assert property (hold_reg <= link_pkg::STRETCH_CYC)
		else $error("clock stretch too long");
	a_stretch_after_ack: assert property ($rose(dev_scl_oe) |-> pack_reg && !scl)
		else $error("stretch outside read acknowledge");

	c_hit: cover property (ack_rise && first_reg && hit);
	c_stretch: cover property ($rose(dev_scl_oe));
	c_restart: cover property (start_det && busy_reg);
	c_stop: cover property (stop_det);
endmodule

// >>> accel_i2c_target_port_bench.sv
// self-checking bench: primary and target ends joined over the link
module accel_i2c_target_port_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic               clk = 1'b0;
	logic               resetn = 1'b0;
	logic               cmd_valid = 1'b0;
	link_pkg::host_op_t cmd_op = link_pkg::bus_start;
	logic [7:0]         cmd_data = 8'h00;
	logic               address_select_pin = 1'b0;
	logic               interface_select_pin = 1'b0;
	logic [7:0]         rd_data = 8'h00;
	logic               rd_valid = 1'b0;
	logic               cmd_ready, rsp_valid, rsp_nack, wr_strobe, rd_req, bus_busy, selected, rsp_nk;
	logic [7:0]         rsp_data, reg_ptr, wr_addr, wr_data, rsp_q, rd_idx;
	logic [7:0]         regs [256];
	logic [7:0]         model [256];
	logic [15:0]        wq [$];
	int                 err_count = 0;
	int                 checked = 0;
	int                 cycles = 0;
	int                 rd_wait = -1;

	always #2 clk = ~clk;

	two_wire_if link ();
	i2c_primary i_i2c_primary (.clk(clk), .resetn(resetn), .ce(1'b1), .link(link), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .rsp_nack(rsp_nack));
	accel_i2c_target_port i_accel_i2c_target_port (.clk(clk), .resetn(resetn), .ce(1'b1), .link(link),
		.address_select_pin(address_select_pin), .interface_select_pin(interface_select_pin),
		.reg_ptr(reg_ptr), .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data), .rd_req(rd_req),
		.rd_data(rd_data), .rd_valid(rd_valid), .bus_busy(bus_busy), .selected(selected));
	accel_i2c_target_port_chk i_accel_i2c_target_port_chk (.clk(clk), .resetn(resetn),
		.dev_scl_oe(link.dev_scl_oe), .dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda),
		.address_select_pin(address_select_pin), .interface_select_pin(interface_select_pin));

	////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input bit ok, input string msg);
		checked++;
		if (!ok) begin
			err_count++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask

	// register file: answers each fetch after a random delay
	always @(posedge clk) begin
		cycles <= cycles + 1;
		rd_valid <= rd_req !== 1'b1 && rd_wait == 0;
		if (rd_req === 1'b1) begin
			rd_idx <= reg_ptr;
			rd_wait <= $urandom_range(40, 0);
		end else if (rd_wait > 0) begin
			rd_wait <= rd_wait - 1;
		end else if (rd_wait == 0) begin
			rd_data <= regs[rd_idx];
			rd_wait <= -1;
		end
		if (wr_strobe === 1'b1) begin
			regs[wr_addr] <= wr_data;
			check(wq.size() > 0 && wq.pop_front() === {wr_addr, wr_data}, "write strobe");
		end
		if (cycles == 90000) begin
			err_count++;
			$display("unexpected at %0t: run too long", $time);
			wrap_up();
		end
	end

	// one primary command, held until taken, then its answer
	task automatic cmd(input link_pkg::host_op_t op, input logic [7:0] d);
		bit r;
		int n;
		r = 1'b0;
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_data <= d;
		while (!r) begin
			@(negedge clk);
			r = cmd_ready === 1'b1;
			@(posedge clk);
		end
		cmd_valid <= 1'b0;
		if (op != link_pkg::bus_start && op != link_pkg::bus_stop) begin
			for (n = 0; n < 5000 && rsp_valid !== 1'b1; n++)
				@(negedge clk);
			check(n < 5000, "no byte answer");
			rsp_q = rsp_data;
			rsp_nk = rsp_nack;
		end
		@(posedge clk);
	endtask

	task automatic stop_idle();
		int n;
		cmd(link_pkg::bus_stop, 8'h00);
		for (n = 0; n < 400 && bus_busy !== 1'b0; n++)
			@(posedge clk);
		check(bus_busy === 1'b0 && selected === 1'b0 && wq.size() == 0, "bus free after stop");
	endtask

	task automatic wr_txn(input logic [6:0] a, input logic [7:0] ptr, input int n, input bit hit);
		logic [7:0] d;
		cmd(link_pkg::bus_start, 8'h00);
		cmd(link_pkg::byte_write, {a, 1'b0});
		check(bus_busy === 1'b1 && selected === hit, "busy after start");
		check(rsp_nk === !hit, "address acknowledge");
		if (hit) begin
			cmd(link_pkg::byte_write, ptr);
			check(rsp_nk === 1'b0 && reg_ptr === ptr, "pointer load");
			for (int i = 0; i < n; i++) begin
				d = 8'($urandom);
				wq.push_back({8'(ptr + i), d});
				model[8'(ptr + i)] = d;
				cmd(link_pkg::byte_write, d);
				check(rsp_nk === 1'b0, "data acknowledge");
			end
			check(reg_ptr === 8'(ptr + n), "pointer advance");
		end
		stop_idle();
	endtask

	task automatic rd_txn(input logic [6:0] a, input logic [7:0] ptr, input int n);
		cmd(link_pkg::bus_start, 8'h00);
		cmd(link_pkg::byte_write, {a, 1'b0});
		cmd(link_pkg::byte_write, ptr);
		cmd(link_pkg::bus_start, 8'h00);
		cmd(link_pkg::byte_write, {a, 1'b1});
		check(rsp_nk === 1'b0, "read address acknowledge");
		for (int i = 0; i < n; i++) begin
			cmd(i == n - 1 ? link_pkg::byte_read_nack : link_pkg::byte_read_ack, 8'h00);
			check(rsp_q === model[8'(ptr + i)], "read data");
		end
		stop_idle();
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h6c02));
		foreach (regs[i]) begin
			regs[i] = 8'($urandom);
			model[i] = regs[i];
		end
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		repeat (3) @(posedge clk);
		check(bus_busy === 1'b0 && selected === 1'b0 && reg_ptr === 8'h00, "reset state");
		$display("test reset done");
		for (int s = 0; s < 2; s++) begin
			address_select_pin <= s[0];
			repeat (4) @(posedge clk);
			for (int k = 0; k < 2; k++)
				wr_txn(7'h18 + 7'(k), k ? 8'hfe : 8'($urandom), 2, k == s);
			$display("test strap %0d done", s);
		end
		interface_select_pin <= 1'b1;
		repeat (4) @(posedge clk);
		wr_txn(7'h19, 8'h10, 1, 1'b0);
		interface_select_pin <= 1'b0;
		repeat (4) @(posedge clk);
		$display("test port off done");
		rd_txn(7'h19, 8'hff, 3);
		rd_txn(7'h19, 8'($urandom), 2);
		$display("test reads done");
		wrap_up();
	end
endmodule
